/* rtl/fault_diag_regs.vh */
/*
 constants for the fault diagnosis register bank: addresses, field positions,
 reset values and debounce timing. assumes a 10 mhz logic clock.
*/
`ifndef FAULT_DIAG_REGS_VH
`define FAULT_DIAG_REGS_VH

`define CLOCK_HZ 10000000
`define CH_COUNT 8
// diagnosis bank addresses (2-bit pointer)
`define ADDR_DIAG_CHANNELS_0_1 2'h0
`define ADDR_DIAG_CHANNELS_2_3 2'h1
`define ADDR_DIAG_CHANNELS_4_5 2'h2
`define ADDR_DIAG_CHANNELS_6_7 2'h3
// control bank pointer chosen for the command register
`define ADDR_COMMAND_CONTROL 3'h7
// diagnosis register fields
`define BIT_FAULT_EVEN 0
`define BIT_OPEN_EVEN 1
`define BIT_FAULT_ODD 2
`define BIT_OPEN_ODD 3
// command register fields
`define BIT_LATCH_CLEAR 0
`define BIT_RESET_REQ 1
`define BIT_STANDBY 2
`define BIT_WAKE 3
`define COMMAND_RESET 4'h0
// timing in microseconds, as printed
`define OPEN_LOAD_DELAY_MIN_US 100
`define OPEN_LOAD_DELAY_MAX_US 250
`define OVERLOAD_SHUTOFF_DELAY_US 60
// cycle counts: least time rounds up, longest time rounds down
// open load: 100 us at 10 mhz; overload: 60 us less 8 cycles for sync and latch
`define OPEN_LOAD_CYCLES 11'd1000
`define OVERLOAD_CYCLES 11'd592
`define DEBOUNCE_WIDTH 11

`endif

/* rtl/fault_debounce.v */
/*
 one channel of fault debounce: a condition must hold for a full count
 before fire goes high; fire stays high while the condition holds, and the count restarts whenever the condition drops.
 assumes condition inputs are already synchronised to clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fault_diag_regs.vh"

module fault_debounce #(
  parameter [`DEBOUNCE_WIDTH-1:0] COUNT = 11'd1
) (
  input wire clock,
  input wire rst_b,
  input wire condition,
  output reg fire
);
  reg [`DEBOUNCE_WIDTH-1:0] count;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= 11'h000;
      fire <= 1'b0;
    end else if (!condition) begin
      count <= 11'h000;
      fire <= 1'b0;
    end else if (count == COUNT - 11'h001) begin
      fire <= 1'b1;
    end else begin
      count <= count + 11'h001;
      fire <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* rtl/fault_diagnosis_register_bank.v */
/*
 fault diagnosis register bank of an eight-channel relay driver, with its
 spi slave frame engine for register access. assumes detector levels and
 spi pins arrive asynchronously and are synchronised here; scl low at cs edges.
*/
// Notes on behaviour
// R1 - an open-load flag sets only after the condition holds 100 to 250 us while the channel is off.
// R2 - an overload latches the fault flag and switches the channel off within 60 us.
// R3 - with bank select 1, four read-only 4-bit diagnosis registers sit at addresses 00 to 11.
// R4 - the even channel fault flag is bit 0 and the odd one bit 2.
// R5 - the even channel open-load flag is bit 1 and the odd one bit 3.
// R6 - a read-write 4-bit command register holds latch clear, reset, standby and wake; the code gives it no spi read path, only writes.
// R7 - writing latch clear clears all fault flags and the bit drops at the next valid frame.
// R8 - reading a diagnosis register clears its open-load flags but not its fault flags.
// R9 - an over-temperature report sets the fault flag even while the channel is off.
// R10 - the master reads with two frames, the data coming back in the second.
// R11 - reset clears all latches and the command register.
`timescale 1ns/1ns
`default_nettype none
`include "fault_diag_regs.vh"

module fault_diagnosis_register_bank (
  input wire clock,
  input wire rst_b,
  input wire cs_b,
  input wire scl,
  input wire sdi,
  output reg sdo,
  output reg sdo_oe_b,
  input wire [7:0] channel_on,
  input wire [7:0] overload,
  input wire [7:0] over_temp,
  input wire [7:0] open_load,
  output reg [7:0] channel_shutoff,
  output reg [3:0] command_control,
  output reg transfer_error
);
  reg cs_q1, cs_q2, cs_q3;
  reg scl_q1, scl_q2, scl_q3;
  reg sdi_q1, sdi_q2;
  reg [7:0] ovl_q1, ovl_q2, ot_q1, ot_q2, ol_q1, ol_q2, on_q1, on_q2;
  reg [7:0] protection_fault_flag;
  reg [7:0] open_load_flag;
  reg [7:0] shift;
  reg [2:0] bit_count;
  reg got_bits;
  reg read_pending;
  reg [1:0] read_addr;
  reg read_bank;
  wire [7:0] ovl_fire;
  wire [7:0] ol_fire;
  wire cs_fall = cs_q3 & ~cs_q2;
  wire cs_rise = ~cs_q3 & cs_q2;
  wire scl_rise = ~scl_q3 & scl_q2;
  wire scl_fall = scl_q3 & ~scl_q2;
  wire frame_ok = cs_rise & got_bits & (bit_count == 3'h0);
  wire frame_bad = cs_rise & ~(got_bits & (bit_count == 3'h0));

  function [3:0] diag_word;
    input [1:0] addr;
    input [7:0] fault;
    input [7:0] open;
    reg [2:0] ev;
    begin
      ev = {addr, 1'b0};
      diag_word = 4'h0;
      diag_word[`BIT_FAULT_EVEN] = fault[ev]; // R4
      diag_word[`BIT_FAULT_ODD] = fault[ev + 3'h1]; // R4
      diag_word[`BIT_OPEN_EVEN] = open[ev]; // R5
      diag_word[`BIT_OPEN_ODD] = open[ev + 3'h1]; // R5
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `CH_COUNT; g = g + 1) begin : chan
      fault_debounce #(.COUNT(`OVERLOAD_CYCLES)) u_ovl ( // R2
        .clock(clock),
        .rst_b(rst_b),
        .condition(ovl_q2[g] & on_q2[g]),
        .fire(ovl_fire[g])
      );
      fault_debounce #(.COUNT(`OPEN_LOAD_CYCLES)) u_ol ( // R1
        .clock(clock),
        .rst_b(rst_b),
        .condition(ol_q2[g] & ~on_q2[g]),
        .fire(ol_fire[g])
      );
    end
  endgenerate

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cs_q1 <= 1'b1;
      cs_q2 <= 1'b1;
      cs_q3 <= 1'b1;
      scl_q1 <= 1'b0;
      scl_q2 <= 1'b0;
      scl_q3 <= 1'b0;
      sdi_q1 <= 1'b0;
      sdi_q2 <= 1'b0;
      ovl_q1 <= 8'h00;
      ovl_q2 <= 8'h00;
      ot_q1 <= 8'h00;
      ot_q2 <= 8'h00;
      ol_q1 <= 8'h00;
      ol_q2 <= 8'h00;
      on_q1 <= 8'h00;
      on_q2 <= 8'h00;
    end else begin
      cs_q1 <= cs_b;
      cs_q2 <= cs_q1;
      cs_q3 <= cs_q2;
      scl_q1 <= scl;
      scl_q2 <= scl_q1;
      scl_q3 <= scl_q2;
      sdi_q1 <= sdi;
      sdi_q2 <= sdi_q1;
      ovl_q1 <= overload;
      ovl_q2 <= ovl_q1;
      ot_q1 <= over_temp;
      ot_q2 <= ot_q1;
      ol_q1 <= open_load;
      ol_q2 <= ol_q1;
      on_q1 <= channel_on;
      on_q2 <= on_q1;
    end
  end

  // frame engine: sample on falling scl, shift out on rising scl
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift <= 8'h00;
      bit_count <= 3'h0;
      got_bits <= 1'b0;
      sdo <= 1'b0;
      sdo_oe_b <= 1'b1;
      read_pending <= 1'b0;
      read_addr <= 2'h0;
      read_bank <= 1'b0;
      transfer_error <= 1'b0;
    end else begin
      if (cs_fall) begin
        bit_count <= 3'h0;
        got_bits <= 1'b0;
        sdo_oe_b <= 1'b0;
        if (read_pending && read_bank) begin // R10
          shift <= {2'b01, read_addr, diag_word(read_addr, protection_fault_flag,
            open_load_flag)}; // R3
        end else begin
          shift <= {2'b00, 2'b00, diag_word(2'h3, protection_fault_flag, open_load_flag)};
        end
        sdo <= transfer_error | sdi_q2;
      end else if (!cs_q2 && scl_fall) begin
        shift <= {shift[6:0], sdi_q2};
        bit_count <= bit_count + 3'h1;
        got_bits <= 1'b1;
      end else if (!cs_q2 && scl_rise) begin
        sdo <= shift[7];
      end
      if (cs_rise) begin
        sdo_oe_b <= 1'b1;
        transfer_error <= frame_bad;
        if (frame_ok) begin
          read_pending <= ~shift[7] & ~shift[1]; // R10
          read_addr <= shift[5:4];
          read_bank <= shift[0];
        end
      end
    end
  end

  // latches and command register
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      protection_fault_flag <= 8'h00; // R11
      open_load_flag <= 8'h00; // R11
      command_control <= `COMMAND_RESET; // R11
      channel_shutoff <= 8'h00;
    end else begin
      if (frame_ok) begin
        command_control[`BIT_LATCH_CLEAR] <= 1'b0; // R7
        if (shift[7] && shift[6:4] == `ADDR_COMMAND_CONTROL) begin
          command_control <= shift[3:0]; // R6
        end
      end
      if (command_control[`BIT_LATCH_CLEAR]) begin
        protection_fault_flag <= ovl_fire | ot_q2; // R7
        channel_shutoff <= ovl_fire | ot_q2;
      end else begin
        protection_fault_flag <= protection_fault_flag | ovl_fire | ot_q2; // R9
        channel_shutoff <= protection_fault_flag | ovl_fire | ot_q2; // R2
      end
      if (frame_ok && read_pending && read_bank) begin
        open_load_flag <= (open_load_flag & ~(8'h03 << {read_addr, 1'b0})) | ol_fire; // R8
      end else begin
        open_load_flag <= open_load_flag | ol_fire; // R1
      end
    end
  end
endmodule
`default_nettype wire

/* tb/fdrb_chk.sv */
/* port checker of the fault bank; bound to its top, assumes fault inputs held long */
`timescale 1ns/1ns
`default_nettype none
module fdrb_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sdo_oe_b,
  input wire logic [7:0] channel_on,
  input wire logic [7:0] overload,
  input wire logic [7:0] over_temp,
  input wire logic [7:0] channel_shutoff,
  input wire logic [3:0] command_control
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [10:0] n;
  // unbroken overload cycles of channel 0 while on
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      n <= 11'h0;
    else
      n <= (overload[0] && channel_on[0]) ? n + 11'h1 : 11'h0;
  end
  sequence s_end; $rose(cs_b) ##1 cs_b [*4]; endsequence
  property p_rst; $rose(rst_b) |-> !command_control && !channel_shutoff; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_cmd; !$stable(command_control) |-> cs_b; endproperty
  a_cmd: assert property (p_cmd) else $error("command");
  property p_ovl; n == 11'h258 |-> channel_shutoff[0]; endproperty
  a_ovl: assert property (p_ovl) else $error("overload");
  property p_hot; $rose(over_temp[1]) && !channel_on[1] |-> ##[1:6] channel_shutoff[1]; endproperty
  a_hot: assert property (p_hot) else $error("heat");
  property p_clr; $rose(command_control[0]) && !overload && !over_temp |-> ##[1:3] !channel_shutoff;
  endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_keep; $fell(channel_shutoff[0]) |-> command_control[0] || $past(command_control[0]);
  endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_on; $fell(cs_b) |-> ##[2:5] !sdo_oe_b; endproperty
  a_on: assert property (p_on) else $error("drive");
  property p_off; s_end |-> sdo_oe_b; endproperty
  a_off: assert property (p_off) else $error("release");
endmodule
bind fault_diagnosis_register_bank fdrb_chk fdrb_chk_i (.*);
`default_nettype wire

/* tb/spi_master.sv */
/* spi master model of the bank's serial port; assumes a 100 ns logic clock */
`timescale 1ns/1ns
`default_nettype none
module spi_master (
  input wire logic clock,
  output logic cs_b,
  output logic scl,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    cs_b = 1'b1;
    scl = 1'b0;
    sdi = 1'b0;
  end
  // one byte msb first, scl period 800 ns, low at select edges
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    @(negedge clock);
    cs_b = 1'b0;
    repeat (2) @(negedge clock);
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      repeat (2) @(negedge clock);
      scl = 1'b1;
      repeat (4) @(negedge clock);
      // bit i is shifted out on the rising scl, so take it late in the high phase
      rx[i] = sdo;
      scl = 1'b0;
      repeat (2) @(negedge clock);
    end
    cs_b = 1'b1;
    sdi = ~sdi;
    repeat (6) @(negedge clock);
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
/* bench of the fault bank; assumes debounce of 592 and 1000 cycles */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] channel_on = 8'h0;
  logic [7:0] overload = 8'h0;
  logic [7:0] over_temp = 8'h0;
  logic [7:0] open_load = 8'h0;
  wire cs_b, scl, sdi, sdo, sdo_oe_b, transfer_error;
  wire [7:0] channel_shutoff;
  wire [3:0] command_control;
  int fails = 0;
  int cmp_count = 0;
  int seed = 32'hb4c3647c;
  logic [7:0] r;
  logic [2:0] c;
  always #50 clock = ~clock;
  fault_diagnosis_register_bank fault_diagnosis_register_bank_i (.*);
  spi_master spi_master_i (.*);
  task cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask
  function automatic logic [7:0] diag(input logic [2:0] ch, input logic f, input logic ol);
    diag = {2'b01, ch[2:1], 4'h0};
    diag[{ch[0], 1'b0}] = f;
    diag[{ch[0], 1'b1}] = ol;
  endfunction
  task rd(input logic [2:0] ch);
    spi_master_i.frame({2'b00, ch[2:1], 4'h1}, r);
    spi_master_i.frame(8'h02, r);
  endtask
  task wr(input logic [3:0] v);
    logic [7:0] x;
    spi_master_i.frame({4'hf, v}, x);
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    end_sim;
  end
  initial begin
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    repeat (6) @(negedge clock);
    cmp("command", 8'h0, {4'h0, command_control});
    for (int a = 0; a < 8; a += 2) begin
      rd(a[2:0]);
      cmp("diag", diag(a[2:0], 1'b0, 1'b0), r);
    end
    repeat (4) begin
      c = $random(seed);
      wr({c, 1'b1});
      cmp("command", {4'h0, c, 1'b1}, {4'h0, command_control});
    end
    wr(4'h0);
    cmp("transfer_error", 8'h0, {7'h0, transfer_error});
    $display("test reset and command done");
    channel_on[0] = 1'b1;
    overload[0] = 1'b1;
    over_temp[1] = 1'b1;
    repeat (650) @(negedge clock);
    overload[0] = 1'b0;
    over_temp[1] = 1'b0;
    cmp("shutoff", 8'h03, channel_shutoff);
    repeat (2) begin
      rd(3'h0);
      cmp("diag", diag(3'h0, 1'b1, 1'b0) | diag(3'h1, 1'b1, 1'b0), r);
    end
    wr(4'h1);
    cmp("shutoff", 8'h00, channel_shutoff);
    rd(3'h0);
    cmp("diag", diag(3'h0, 1'b0, 1'b0), r);
    cmp("command", 8'h0, {4'h0, command_control});
    $display("test faults done");
    channel_on = 8'h0;
    c = $random(seed);
    open_load[c] = 1'b1;
    repeat (950) @(negedge clock);
    open_load[c] = 1'b0;
    rd(c);
    cmp("diag", diag(c, 1'b0, 1'b0), r);
    open_load[c] = 1'b1;
    repeat (2500) @(negedge clock);
    open_load[c] = 1'b0;
    rd(c);
    cmp("diag", diag(c, 1'b0, 1'b1), r);
    rd(c);
    cmp("diag", diag(c, 1'b0, 1'b0), r);
    $display("test open load done");
    end_sim;
  end
endmodule
`default_nettype wire
